// ==== src/mvd_consts.vh ====
// constants for the multiport video dram special-cycle controller
`ifndef MVD_CONSTS_VH
`define MVD_CONSTS_VH
// register offsets (byte addresses)
`define MVD_OFF_CMD 12'h000
`define MVD_OFF_ADDR 12'h004
`define MVD_OFF_DATA 12'h008
`define MVD_OFF_STAT 12'h00C
`define MVD_OFF_RDAT 12'h010
`define MVD_OFF_REFR 12'h014
// command codes in cmd register bits 3:0
`define MVD_CMD_READ 4'h1
`define MVD_CMD_WRITE 4'h2
`define MVD_CMD_BFILL 4'h3
`define MVD_CMD_FLASH 4'h4
`define MVD_CMD_MLOAD 4'h5
`define MVD_CMD_CLOAD 4'h6
`define MVD_CMD_RFRST 4'h7
`define MVD_CMD_RFONLY 4'h8
`define MVD_CMD_RFBND 4'h9
// cmd register field bits
`define MVD_CMD_MASKED 4
`define MVD_CMD_PIPE 5
// address register fields: row 17:9, column 8:0
`define MVD_ROW_HI 17
`define MVD_ROW_LO 9
`define MVD_COL_HI 8
`define MVD_COL_LO 0
// smallest allowed stop register value
`define MVD_STOP_MIN 9'h00F
// timing
`define MVD_CLK_NS 100
`define MVD_REF_PERIOD_NS 8000000
`define MVD_REF_ROWS 512
`define MVD_PHASE_CYC 4'h1
`define MVD_PRE_CYC 4'h2
`define MVD_SYNC_CYC 4'h2
`endif

// ==== src/mvd_ctrl.v ====
// host controller issuing special-function cycles to a multiport video dram
//
// Behaviour
// - flash: cas high, we low, sf1 high
// - new mask: drive mask at row fall
// - sf2 high at row fall selects pipelining
// - pipelined column op chosen per cycle
// - pipelined read needs extra column cycle
// - dummy column cycle after pipelined write
// - mask load: all high, sf1 low at cas
// - colour load: all high at row fall
// - refresh all 512 rows per 8 ms
// - no refresh-only during power-up init
// - boundary set: cas low, we, sf1 high
// - stop values 000000111 and below forbidden; code refuses all below 000001111
//
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "mvd_consts.vh"
module mvd_ctrl #(
    parameter REF_INTERVAL = (`MVD_REF_PERIOD_NS / `MVD_REF_ROWS) / `MVD_CLK_NS
) (
    input wire i_clk,
    input wire i_rst_b,
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [11:0] i_paddr,
    input wire [31:0] i_pwdata,
    output wire [31:0] o_prdata,
    output wire o_pready,
    output wire o_pslverr,
    output reg o_row_strobe_n,
    output reg o_col_strobe_n,
    output reg o_transfer_output_enable_n,
    output reg o_mask_write_enable_n,
    output reg o_special_function_1,
    output reg o_special_function_2,
    output reg [8:0] o_address_bits_0_to_8,
    input wire [7:0] i_mask_data_lines,
    output reg [7:0] o_mask_data_lines,
    output reg o_mask_data_lines_oe
);
    localparam ST_IDLE = 4'h0;
    localparam ST_ROW = 4'h1;
    localparam ST_RAS = 4'h2;
    localparam ST_COL = 4'h3;
    localparam ST_CAS = 4'h4;
    localparam ST_EXTRA = 4'h5;
    localparam ST_DUMMY = 4'h6;
    localparam ST_END = 4'h7;
    localparam ST_PRE = 4'h8;
    localparam ST_CBR = 4'h9;
    localparam [13:0] REF_CNT = REF_INTERVAL[13:0];

    reg [7:0] cmd_q;
    reg [17:0] addr_q;
    reg [8:0] data_q;
    reg [7:0] rdat_q;
    reg busy_q;
    reg start_q;
    reg old_mask_q;
    reg stop_set_q;
    reg init_done_q;
    reg err_q;
    reg ref_en_q;
    reg ref_due_q;
    reg [13:0] ref_cnt_q;
    reg [8:0] ref_row_q;
    reg is_ref_q;
    reg [3:0] st_q;
    reg [3:0] wait_q;
    reg [7:0] in_s1_q;
    reg [7:0] in_s2_q;

    wire wr_acc = i_psel & i_penable & i_pwrite;
    wire [3:0] op = cmd_q[3:0];
    wire masked = cmd_q[`MVD_CMD_MASKED];
    wire pipe = cmd_q[`MVD_CMD_PIPE];
    wire is_cbr = (op == `MVD_CMD_RFRST) | (op == `MVD_CMD_RFONLY) | (op == `MVD_CMD_RFBND);
    wire col_op = (op == `MVD_CMD_READ) | (op == `MVD_CMD_WRITE) | (op == `MVD_CMD_BFILL);
    wire col_write = (op == `MVD_CMD_WRITE) | (op == `MVD_CMD_BFILL);
    wire wait_done = (wait_q == 4'h0);
    reg [31:0] rd_mux;

    assign o_pready = 1'b1;
    assign o_pslverr = 1'b0;
    assign o_prdata = (i_psel & ~i_pwrite) ? rd_mux : 32'h0000_0000;

    always @* begin
        case (i_paddr)
            `MVD_OFF_CMD: rd_mux = {24'h00_0000, cmd_q};
            `MVD_OFF_ADDR: rd_mux = {14'h0000, addr_q};
            `MVD_OFF_DATA: rd_mux = {23'h00_0000, data_q};
            `MVD_OFF_STAT: rd_mux = {26'h000_0000, err_q, init_done_q, stop_set_q,
                                     old_mask_q, ref_due_q, busy_q};
            `MVD_OFF_RDAT: rd_mux = {24'h00_0000, rdat_q};
            `MVD_OFF_REFR: rd_mux = {31'h0000_0000, ref_en_q};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // device lines are asynchronous to our clock
    always @(posedge i_clk) begin
        in_s1_q <= i_mask_data_lines;
        in_s2_q <= in_s1_q;
    end

    // spread one row refresh per interval, rows walk 0..511
    always @(posedge i_clk) begin
        if (!i_rst_b) begin
            ref_cnt_q <= 14'h0000;
            ref_due_q <= 1'b0;
        end else begin
            if (ref_cnt_q >= REF_CNT - 14'h0001) begin
                ref_cnt_q <= 14'h0000;
                ref_due_q <= ref_en_q;
            end else begin
                ref_cnt_q <= ref_cnt_q + 14'h0001;
                if (st_q == ST_END && is_ref_q)
                    ref_due_q <= 1'b0;
            end
        end
    end

    always @(posedge i_clk) begin
        if (!i_rst_b) begin
            cmd_q <= 8'h00;
            addr_q <= 18'h0_0000;
            data_q <= 9'h000;
            rdat_q <= 8'h00;
            busy_q <= 1'b0;
            start_q <= 1'b0;
            old_mask_q <= 1'b0;
            stop_set_q <= 1'b0;
            init_done_q <= 1'b0;
            err_q <= 1'b0;
            ref_en_q <= 1'b0;
            ref_row_q <= 9'h000;
            is_ref_q <= 1'b0;
            st_q <= ST_IDLE;
            wait_q <= 4'h0;
            o_row_strobe_n <= 1'b1;
            o_col_strobe_n <= 1'b1;
            o_transfer_output_enable_n <= 1'b1;
            o_mask_write_enable_n <= 1'b1;
            o_special_function_1 <= 1'b0;
            o_special_function_2 <= 1'b0;
            o_address_bits_0_to_8 <= 9'h000;
            o_mask_data_lines <= 8'h00;
            o_mask_data_lines_oe <= 1'b0;
        end else begin
            start_q <= 1'b0;
            if (wr_acc && !busy_q) begin
                case (i_paddr)
                    `MVD_OFF_CMD: begin
                        cmd_q <= i_pwdata[7:0];
                        // refresh-only refused until an option reset has run
                        if (i_pwdata[3:0] == `MVD_CMD_RFONLY && !init_done_q)
                            err_q <= 1'b1;
                        else if (i_pwdata[3:0] == `MVD_CMD_RFBND &&
                                 data_q < `MVD_STOP_MIN)
                            err_q <= 1'b1;
                        else begin
                            err_q <= 1'b0;
                            start_q <= 1'b1;
                            busy_q <= 1'b1;
                        end
                    end
                    `MVD_OFF_ADDR: addr_q <= i_pwdata[17:0];
                    `MVD_OFF_DATA: data_q <= i_pwdata[8:0];
                    `MVD_OFF_REFR: ref_en_q <= i_pwdata[0];
                    default: ;
                endcase
            end
            if (wait_q != 4'h0)
                wait_q <= wait_q - 4'h1;
            case (st_q)
                ST_IDLE: begin
                    if (start_q) begin
                        is_ref_q <= 1'b0;
                        st_q <= is_cbr ? ST_CBR : ST_ROW;
                    end else if (ref_due_q && !busy_q && init_done_q && !wr_acc) begin
                        // a bus write in this cycle may be a command; it goes first
                        // row-only refresh using the hidden row counter
                        is_ref_q <= 1'b1;
                        busy_q <= 1'b1;
                        cmd_q <= 8'h00;
                        st_q <= ST_ROW;
                    end
                end
                ST_ROW: begin
                    // set up mode pins ahead of the row strobe fall
                    o_address_bits_0_to_8 <= is_ref_q ? ref_row_q :
                                             addr_q[`MVD_ROW_HI:`MVD_ROW_LO];
                    o_col_strobe_n <= 1'b1;
                    o_transfer_output_enable_n <= 1'b1;
                    o_special_function_2 <= pipe & col_op;
                    o_mask_data_lines_oe <= 1'b0;
                    if (is_ref_q) begin
                        o_mask_write_enable_n <= 1'b1;
                        o_special_function_1 <= 1'b0;
                    end else if (op == `MVD_CMD_FLASH) begin
                        o_mask_write_enable_n <= 1'b0;
                        o_special_function_1 <= 1'b1;
                    end else if (op == `MVD_CMD_MLOAD || op == `MVD_CMD_CLOAD) begin
                        o_mask_write_enable_n <= 1'b1;
                        o_special_function_1 <= 1'b1;
                    end else begin
                        o_mask_write_enable_n <= ~masked;
                        o_special_function_1 <= 1'b0;
                    end
                    // new mask mode takes the I/O mask at row fall
                    if (!is_ref_q && !old_mask_q && (masked || op == `MVD_CMD_FLASH)) begin
                        o_mask_data_lines <= data_q[7:0];
                        o_mask_data_lines_oe <= 1'b1;
                    end
                    wait_q <= `MVD_PHASE_CYC;
                    st_q <= ST_RAS;
                end
                ST_RAS: if (wait_done) begin
                    o_row_strobe_n <= 1'b0;
                    wait_q <= `MVD_PHASE_CYC;
                    // flash fill and refresh need no column strobe
                    st_q <= (is_ref_q || is_cbr || op == `MVD_CMD_FLASH) ? ST_END :
                            ST_COL;
                end
                ST_COL: if (wait_done) begin
                    o_address_bits_0_to_8 <= addr_q[`MVD_COL_HI:`MVD_COL_LO];
                    o_mask_write_enable_n <= ~(col_write | (op == `MVD_CMD_MLOAD) |
                                              (op == `MVD_CMD_CLOAD));
                    o_transfer_output_enable_n <= (op != `MVD_CMD_READ);
                    o_special_function_1 <= (op == `MVD_CMD_BFILL) |
                                            (op == `MVD_CMD_CLOAD);
                    // block fill column mask; load cycles carry register data
                    o_mask_data_lines <= (op == `MVD_CMD_BFILL) ? {4'h0, data_q[3:0]} :
                                         data_q[7:0];
                    o_mask_data_lines_oe <= (op != `MVD_CMD_READ);
                    wait_q <= `MVD_PHASE_CYC;
                    st_q <= ST_CAS;
                end
                ST_CAS: if (wait_done) begin
                    o_col_strobe_n <= 1'b0;
                    // read data reaches us through two synchroniser stages
                    wait_q <= (op == `MVD_CMD_READ) ? `MVD_SYNC_CYC : `MVD_PHASE_CYC;
                    st_q <= (pipe && op == `MVD_CMD_READ) ? ST_EXTRA :
                            (pipe && col_write) ? ST_DUMMY : ST_END;
                end
                ST_EXTRA: if (wait_done) begin
                    // data emerges one column cycle later in pipelined mode
                    o_col_strobe_n <= ~o_col_strobe_n;
                    if (!o_col_strobe_n) begin
                        wait_q <= `MVD_PHASE_CYC;
                        st_q <= ST_EXTRA;
                    end else begin
                        wait_q <= `MVD_SYNC_CYC;
                        st_q <= ST_END;
                    end
                end
                ST_DUMMY: if (wait_done) begin
                    o_col_strobe_n <= ~o_col_strobe_n;
                    o_mask_write_enable_n <= 1'b1;
                    o_special_function_1 <= 1'b0;
                    o_mask_data_lines_oe <= 1'b0;
                    wait_q <= `MVD_PHASE_CYC;
                    if (!o_col_strobe_n)
                        st_q <= ST_DUMMY;
                    else
                        st_q <= ST_END;
                end
                ST_CBR: begin
                    o_col_strobe_n <= 1'b0;
                    o_special_function_2 <= 1'b0;
                    o_transfer_output_enable_n <= 1'b1;
                    o_special_function_1 <= (op != `MVD_CMD_RFRST);
                    // boundary set wants the write enable pin high, refresh-only low
                    o_mask_write_enable_n <= (op != `MVD_CMD_RFONLY);
                    o_address_bits_0_to_8 <= data_q;
                    o_mask_data_lines_oe <= 1'b0;
                    wait_q <= `MVD_PHASE_CYC;
                    st_q <= ST_RAS;
                    is_ref_q <= 1'b0;
                end
                ST_END: if (wait_done) begin
                    if (!o_col_strobe_n && !is_ref_q && op != `MVD_CMD_FLASH &&
                        !is_cbr && op == `MVD_CMD_READ)
                        rdat_q <= in_s2_q;
                    // track device mask mode and boundaries
                    if (op == `MVD_CMD_MLOAD && !is_ref_q)
                        old_mask_q <= 1'b1;
                    if (op == `MVD_CMD_RFRST && !is_ref_q) begin
                        old_mask_q <= 1'b0;
                        stop_set_q <= 1'b0;
                        init_done_q <= 1'b1;
                    end
                    if (op == `MVD_CMD_RFBND && !is_ref_q)
                        stop_set_q <= 1'b1;
                    if (is_ref_q)
                        ref_row_q <= ref_row_q + 9'h001;
                    o_row_strobe_n <= 1'b1;
                    o_col_strobe_n <= 1'b1;
                    o_mask_data_lines_oe <= 1'b0;
                    o_transfer_output_enable_n <= 1'b1;
                    o_mask_write_enable_n <= 1'b1;
                    o_special_function_1 <= 1'b0;
                    o_special_function_2 <= 1'b0;
                    wait_q <= `MVD_PRE_CYC;
                    st_q <= ST_PRE;
                end
                ST_PRE: if (wait_done) begin
                    busy_q <= 1'b0;
                    is_ref_q <= 1'b0;
                    st_q <= ST_IDLE;
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end
endmodule // mvd_ctrl
`default_nettype wire

// ==== verification/mvd_ctrl_props.sv ====
// concurrent checks on the controller's dram strobes and mode pins
`timescale 1ns/100ps
`default_nettype none
module mvd_ctrl_props (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic o_row_strobe_n,
    input wire logic o_col_strobe_n,
    input wire logic o_transfer_output_enable_n,
    input wire logic o_mask_write_enable_n,
    input wire logic o_special_function_1,
    input wire logic o_special_function_2,
    input wire logic [8:0] o_address_bits_0_to_8,
    input wire logic o_mask_data_lines_oe
);
    wire ras = o_row_strobe_n;
    wire cas = o_col_strobe_n;
    wire toe = o_transfer_output_enable_n;
    wire we = o_mask_write_enable_n;
    wire s1 = o_special_function_1;
    wire s2 = o_special_function_2;
    logic seen_q, pipe_q, pend_q;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    // pend_q is set by a pipelined column op and cleared by the column cycle behind it
    always @(posedge i_clk) begin
        if (!i_rst_b) begin
            seen_q <= 1'b0;
            pipe_q <= 1'b0;
            pend_q <= 1'b0;
        end else begin
            if ($fell(ras) && !cas && !s1)
                seen_q <= 1'b1;
            if ($fell(ras))
                pipe_q <= s2;
            if ($rose(ras))
                pend_q <= 1'b0;
            else if ($fell(cas) && !ras && pipe_q)
                pend_q <= !pend_q;
        end
    end
    property p_flash; $fell(ras) && cas && !we && s1 |-> toe; endproperty
    a_flash: assert property (p_flash) else $error("flash fill with output enable low");
    property p_pipe; $fell(ras) && s2 |-> cas && toe && !s1; endproperty
    a_pipe: assert property (p_pipe) else $error("pipelined page on a non-page cycle");
    property p_cbr; $fell(ras) && !cas |-> $past(cas) == 1'b0; endproperty
    a_cbr: assert property (p_cbr) else $error("column strobe not ahead of row strobe");
    property p_stop; $fell(ras) && !cas && we && s1 |-> o_address_bits_0_to_8 > 9'h007; endproperty
    a_stop: assert property (p_stop) else $error("forbidden stop value set");
    property p_load; $fell(ras) && cas && toe && we && s1 |-> ##[1:30] ($fell(cas) && !ras);
    endproperty
    a_load: assert property (p_load) else $error("load cycle without column strobe");
    property p_rd; !ras && !toe && we |-> !o_mask_data_lines_oe; endproperty
    a_rd: assert property (p_rd) else $error("controller drives data during a read");
    property p_ronly; $fell(ras) && !cas && s1 && !we |-> seen_q; endproperty
    a_ronly: assert property (p_ronly) else $error("refresh-only before option reset");
    property p_tail; $rose(ras) |-> !pend_q; endproperty
    a_tail: assert property (p_tail) else $error("page closed without trailing column");
endmodule // mvd_ctrl_props
bind mvd_ctrl mvd_ctrl_props u_props (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .o_row_strobe_n(o_row_strobe_n), .o_col_strobe_n(o_col_strobe_n),
    .o_transfer_output_enable_n(o_transfer_output_enable_n),
    .o_mask_write_enable_n(o_mask_write_enable_n), .o_special_function_1(o_special_function_1),
    .o_special_function_2(o_special_function_2), .o_address_bits_0_to_8(o_address_bits_0_to_8),
    .o_mask_data_lines_oe(o_mask_data_lines_oe));
`default_nettype wire

// ==== verification/mvd_dev_model.sv ====
// behavioural model of the video dram random port and its special cycles
`timescale 1ns/100ps
`default_nettype none
module mvd_dev_model (
    input wire logic i_ras_n,
    input wire logic i_cas_n,
    input wire logic i_toe_n,
    input wire logic i_we_n,
    input wire logic i_sf1,
    input wire logic i_sf2,
    input wire logic [8:0] i_a,
    input wire logic [7:0] i_dq,
    output logic [7:0] o_dq,
    output logic o_dq_en
);
    logic [7:0] mem [0:262143];
    logic [7:0] colour_q = 8'h00, wmask_q = 8'h00, io_m, rd_q;
    logic [8:0] stop_q = 9'h0FF, row_q, ref_row;
    logic old_q = 1'b0, pipe_q, ld_mask;
    int kind = 0, n_ras = 0;
    assign o_dq_en = !i_toe_n && !i_ras_n && kind == 2;
    task automatic load;
        if (ld_mask) begin
            wmask_q = i_dq;
            old_q = 1'b1;
        end else
            colour_q = i_dq;
    endtask
    // sampling 1 ns late keeps pins launched on the same clock edge out of a race
    always @(negedge i_ras_n) begin
        #1;
        row_q = i_a;
        n_ras++;
        pipe_q = i_sf2;
        if (!i_cas_n) begin
            // without option reset or boundary set only the refresh happens
            if (!i_sf1) begin
                old_q = 1'b0;
                stop_q = 9'h0FF;
            end else if (i_we_n)
                stop_q = i_a;
        end else if (i_toe_n) begin
            if (!i_we_n && !old_q)
                wmask_q = i_dq;
            io_m = i_we_n ? 8'hFF : wmask_q;
            if (i_sf1 && !i_we_n)
                for (int c = 0; c < 512; c++)
                    mem[{row_q, c[8:0]}] = (mem[{row_q, c[8:0]}] & ~io_m) | (colour_q & io_m);
            else if (i_sf1) begin
                kind = 1;
                ref_row = row_q;
            end else
                kind = 2;
        end
    end
    always @(negedge i_cas_n) begin
        #1;
        if (kind == 1) begin
            ld_mask = !i_sf1;
            if (!i_we_n)
                load();
        end else if (kind == 2) begin
            if (pipe_q)
                o_dq = rd_q;
            if (i_sf1) begin
                for (int j = 0; j < 4; j++)
                    if (i_dq[j])
                        mem[{row_q, i_a[8:2], j[1:0]}] = colour_q;
            end else if (!i_we_n)
                mem[{row_q, i_a}] = (mem[{row_q, i_a}] & ~io_m) | (i_dq & io_m);
            else
                rd_q = mem[{row_q, i_a}];
            if (!pipe_q)
                o_dq = rd_q;
        end
    end
    always @(negedge i_we_n) begin
        #1;
        if (kind == 1 && !i_cas_n)
            load();
    end
    always @(posedge i_ras_n)
        kind = 0;
endmodule // mvd_dev_model
`default_nettype wire

// ==== verification/mvd_ctrl_test.sv ====
// self-checking bench for the dram special-cycle controller
`timescale 1ns/100ps
`default_nettype none
`include "mvd_consts.vh"
module mvd_ctrl_test;
    logic i_clk = 1'b0, i_rst_b = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [11:0] padr = 12'h000;
    logic [31:0] pwd = 32'h0, rd, seed = 32'h40C39726;
    logic [7:0] v, kc, km, e, last = 8'h00;
    logic [17:0] ad;
    wire rdy, slv, ras, cas, toe, we, sf1, sf2, coe, den;
    wire [31:0] prd;
    wire [8:0] adr;
    wire [7:0] cdq, ddq, dq;
    int fail_count = 0, n_tests = 0, cnt;
    always #50 i_clk = ~i_clk;
    assign dq = (coe === 1'b1) ? cdq : (den === 1'b1) ? ddq : ~last;
    always @(posedge i_clk) if (coe === 1'b1 || den === 1'b1) last <= dq;
    mvd_ctrl #(.REF_INTERVAL(4)) i_dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_psel(psel),
        .i_penable(pen), .i_pwrite(pwr), .i_paddr(padr), .i_pwdata(pwd), .o_prdata(prd),
        .o_pready(rdy), .o_pslverr(slv), .o_row_strobe_n(ras), .o_col_strobe_n(cas),
        .o_transfer_output_enable_n(toe), .o_mask_write_enable_n(we),
        .o_special_function_1(sf1), .o_special_function_2(sf2), .o_address_bits_0_to_8(adr),
        .i_mask_data_lines(dq), .o_mask_data_lines(cdq), .o_mask_data_lines_oe(coe));
    mvd_dev_model u_dev (.i_ras_n(ras), .i_cas_n(cas), .i_toe_n(toe), .i_we_n(we),
        .i_sf1(sf1), .i_sf2(sf2), .i_a(adr), .i_dq(dq), .o_dq(ddq), .o_dq_en(den));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] fillv(input logic [7:0] o, k, m);
        return (o & ~m) | (k & m);
    endfunction
    task automatic final_report;
        if (fail_count == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        n_tests++;
        if (g !== x) begin
            $display("[FAIL] %s expected %h seen %h", nm, x, g);
            fail_count++;
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge i_clk);
        psel <= 1'b1;
        pwr <= w;
        padr <= a;
        pwd <= d;
        @(posedge i_clk);
        pen <= 1'b1;
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (rdy !== 1'b1 && n < 50);
        rd = prd;
        psel <= 1'b0;
        pen <= 1'b0;
        if (n >= 50) begin
            fail_count++;
            final_report();
        end
    endtask
    task automatic run(input logic [7:0] op, input logic [17:0] a, input logic [31:0] d);
        int n;
        apb(1'b1, `MVD_OFF_ADDR, {14'h0, a});
        apb(1'b1, `MVD_OFF_DATA, d);
        apb(1'b1, `MVD_OFF_CMD, {24'h0, op});
        n = 0;
        do begin
            apb(1'b0, `MVD_OFF_STAT, 32'h0);
            n++;
        end while (rd[0] !== 1'b0 && n < 100);
        if (n >= 100) begin
            fail_count++;
            final_report();
        end
    endtask
    task automatic rdc(input logic [17:0] a, input logic [7:0] op);
        run(op, a, 32'h0);
        apb(1'b0, `MVD_OFF_RDAT, 32'h0);
    endtask
    initial begin
        repeat (6) @(posedge i_clk);
        i_rst_b <= 1'b1;
        run(8'h08, 18'h0, 32'h0);
        chk("refresh-only early", 32'h20, rd & 32'h20);
        run(8'h07, 18'h0, 32'h0);
        chk("init done", 32'h10, rd & 32'h10);
        chk("stop reset", 32'h0FF, {23'h0, u_dev.stop_q});
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            v = seed[31:24];
            run({2'b00, i[0], 5'h02}, seed[17:0], {24'h0, v});
            rdc(seed[17:0], {2'b00, i[1], 5'h01});
            chk("read back", {24'h0, v}, rd & 32'hFF);
        end
        // new mask mode: the mask at row fall equals the data, so bits only rise
        seed = lfsr(seed);
        run(8'h02, seed[17:0], {24'h0, seed[31:24]});
        run(8'h12, seed[17:0], {24'h0, seed[23:16]});
        rdc(seed[17:0], 8'h01);
        chk("masked write", {24'h0, seed[31:24] | seed[23:16]}, rd & 32'hFF);
        seed = lfsr(seed);
        kc = seed[7:0];
        km = seed[15:8];
        run(8'h06, 18'h0, {24'h0, kc});
        chk("colour", {24'h0, kc}, {24'h0, u_dev.colour_q});
        run(8'h05, 18'h00600, {24'h0, km});
        chk("write mask", {24'h0, km}, {24'h0, u_dev.wmask_q});
        chk("refreshed row", 32'h3, {23'h0, u_dev.ref_row});
        chk("old mask flag", 32'h4, rd & 32'h4);
        seed = lfsr(seed);
        ad = seed[17:0];
        v = seed[31:24];
        run(8'h02, ad, {24'h0, v});
        run(8'h04, {ad[17:9], 9'h0}, 32'h0);
        rdc(ad, 8'h01);
        chk("flash cell", {24'h0, fillv(v, kc, km)}, rd & 32'hFF);
        for (int j = 0; j < 4; j++)
            run(8'h02, {ad[17:2], j[1:0]}, {24'h0, v ^ j[7:0]});
        run(8'h03, {ad[17:2], 2'b01}, {28'h0, seed[11:8]});
        for (int j = 0; j < 4; j++) begin
            e = fillv(v ^ j[7:0], kc, {8{seed[8 + j]}});
            rdc({ad[17:2], j[1:0]}, 8'h01);
            chk("block fill", {24'h0, e}, rd & 32'hFF);
        end
        run(8'h08, 18'h0, 32'h0);
        chk("mask mode kept", 32'h1, {31'h0, u_dev.old_q});
        run(8'h09, 18'h0, 32'h7);
        chk("stop refused", 32'h0FF, {23'h0, u_dev.stop_q});
        run(8'h09, 18'h0, 32'h1F);
        chk("stop set", 32'h01F, {23'h0, u_dev.stop_q});
        run(8'h08, 18'h0, 32'h0);
        chk("stop kept", 32'h01F, {23'h0, u_dev.stop_q});
        run(8'h07, 18'h0, 32'h0);
        chk("new mask again", 32'h0, rd & 32'h4);
        chk("stop cleared", 32'h0FF, {23'h0, u_dev.stop_q});
        apb(1'b0, 12'h020, 32'h0);
        chk("unmapped", 32'h0, rd);
        chk("slave error", 32'h0, {31'h0, slv});
        cnt = u_dev.n_ras;
        apb(1'b1, `MVD_OFF_REFR, 32'h1);
        repeat (300) @(posedge i_clk);
        chk("auto refresh", 32'h1, {31'h0, (u_dev.n_ras - cnt) > 8});
        final_report();
    end
endmodule // mvd_ctrl_test
`default_nettype wire
